// ==== hvr_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// low-voltage side command issuer
// ****
module hvr_ctrl_model (
    // clock
    input  wire logic       clk,
    // request from the bench
    input  wire logic       req,
    input  wire logic [7:0] req_code,
    input  wire logic [7:0] req_wdata,
    // keyhole command port
    output logic            cmd_valid,
    output logic [7:0]      cmd_code,
    output logic [7:0]      cmd_wdata
);
    // one pulse per request cycle; idle lines flip every cycle so a stale byte never holds steady
    initial begin
        cmd_valid = 1'b0;
        cmd_code  = 8'h00;
        cmd_wdata = 8'h00;
        forever begin
            @(posedge clk);
            cmd_valid <= req;
            cmd_code  <= req ? req_code : ~cmd_code;
            cmd_wdata <= req ? req_wdata : ~cmd_wdata;
        end
    end
endmodule // hvr_ctrl_model
`default_nettype wire

// ==== hvr_pkg.sv ====
`default_nettype none
package hvr_pkg;
    // ****************************************************
    // command codes on the keyhole port
    // ****************************************************
    localparam logic [7:0] CMD_READ_CONFIG  = 8'h00;
    localparam logic [7:0] CMD_READ_STATUS  = 8'h02;
    localparam logic [7:0] CMD_READ_FIXED   = 8'h05;
    localparam logic [7:0] CMD_WRITE_CONFIG = 8'h08;

    // ****************************************************
    // hv_config field positions and reset
    // ****************************************************
    localparam int CFG_ATTEN_RATIO_SELECT = 5;
    localparam int CFG_LOWV_DETECT_ENABLE = 4;
    localparam int CFG_ATTEN_DIAG_ENABLE  = 3;
    localparam int CFG_DRIVER_REENABLE    = 2;
    localparam int CFG_SHORT_AUTODIS_OFF  = 1;
    localparam int CFG_TX_ENABLE          = 0;
    localparam logic [7:0] CFG_RESET      = 8'h00;
    localparam logic [7:0] CFG_WRITE_MASK = 8'h3f; // bits 7:6 read zero

    // ****************************************************
    // hv_status field positions and fixed pattern
    // ****************************************************
    localparam int STA_LOWV_FLAG    = 2;
    localparam int STA_SHORT_STATUS = 1;
    localparam int STA_SHORT_EVENT  = 0;
    localparam logic [7:0] FIXED_PATTERN = 8'h82;
    localparam logic [3:0] REVISION_DEFAULT = 4'h1; // arbitrary value
endpackage
`default_nettype wire

// ==== hvr_regs.sv ====
`timescale 1ns/1ps
`default_nettype none

module hvr_regs #(
    parameter logic [3:0] REVISION_ID = hvr_pkg::REVISION_DEFAULT
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // keyhole command port
    input  wire logic       cmd_valid,
    input  wire logic [7:0] cmd_code,
    input  wire logic [7:0] cmd_wdata,
    output logic            resp_valid,
    output logic            resp_ack,
    output logic [7:0]      resp_data,
    // analog front end sense
    input  wire logic       bus_dominant,
    input  wire logic       pin_overcurrent,
    input  wire logic       supply_above_limit,
    // analog front end control
    output logic            atten_ratio_select,
    output logic            lowv_detect_enable,
    output logic            atten_diag_current_enable,
    output logic            transmitter_enable,
    output logic            bus_driver_on,
    output logic            hv_irq
);
    // ****************************************************
    // reset synchroniser
    // ****************************************************
    logic rst_meta_q;
    logic rst_n_q;

    // async assert, two-flop release
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ****************************************************
    // command decode
    // ****************************************************
    logic       cfg_q;
    logic [7:0] config_q;
    logic       drv_off_q;
    logic       short_q;
    logic       event_q;
    logic       lowv_q;

    wire is_wr   = cmd_valid && cmd_code == hvr_pkg::CMD_WRITE_CONFIG;
    wire is_rcfg = cmd_valid && cmd_code == hvr_pkg::CMD_READ_CONFIG;
    wire is_rsta = cmd_valid && cmd_code == hvr_pkg::CMD_READ_STATUS;
    wire is_rfix = cmd_valid && cmd_code == hvr_pkg::CMD_READ_FIXED;
    wire cmd_ok  = is_wr || is_rcfg || is_rsta || is_rfix;

    // live short detection and driver shutdown causes
    wire short_now = bus_dominant && pin_overcurrent;
    wire autodis   = !config_q[hvr_pkg::CFG_SHORT_AUTODIS_OFF];
    wire reenable  = is_wr && cmd_wdata[hvr_pkg::CFG_DRIVER_REENABLE];

    // interrupt request: a status read with no live short retires it
    wire irq_d = (event_q || short_now) && !(is_rsta && !short_now);

    // status image; bit 3 reserved and zero
    wire [7:0] status_img = {REVISION_ID, 1'b0, lowv_q,
                             short_q, event_q};

    // read data selection
    wire [7:0] rd_mux = is_rcfg ? config_q :
                        is_rsta ? status_img :
                        is_rfix ? hvr_pkg::FIXED_PATTERN :
                        8'h00;

    // ****************************************************
    // configuration register
    // ****************************************************
    // write stores masked data; re-enable bit drops next cycle
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            config_q <= hvr_pkg::CFG_RESET;
        end else if (is_wr) begin
            config_q <= cmd_wdata & hvr_pkg::CFG_WRITE_MASK;
        end else begin
            config_q[hvr_pkg::CFG_DRIVER_REENABLE] <= 1'b0;
        end
    end
    assign cfg_q = config_q[hvr_pkg::CFG_DRIVER_REENABLE];

    // ****************************************************
    // short-circuit protection and status
    // ****************************************************
    // shutdown wins over re-enable so a standing short stays off
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            drv_off_q <= 1'b0;
        end else if (short_now && autodis) begin
            drv_off_q <= 1'b1;
        end else if (reenable) begin
            drv_off_q <= 1'b0;
        end
    end

    // sticky event: a new short beats a same-cycle read
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            event_q <= 1'b0;
            short_q <= 1'b0;
            lowv_q  <= 1'b0;
        end else begin
            short_q <= short_now;
            lowv_q  <= config_q[hvr_pkg::CFG_LOWV_DETECT_ENABLE]
                       && supply_above_limit;
            if (short_now) begin
                event_q <= 1'b1;
            end else if (is_rsta) begin
                event_q <= 1'b0;
            end
        end
    end

    // ****************************************************
    // outputs, all registered
    // ****************************************************
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            resp_valid                <= 1'b0;
            resp_ack                  <= 1'b0;
            resp_data                 <= 8'h00;
            atten_ratio_select        <= 1'b0;
            lowv_detect_enable        <= 1'b0;
            atten_diag_current_enable <= 1'b0;
            transmitter_enable        <= 1'b0;
            bus_driver_on             <= 1'b0;
            hv_irq                    <= 1'b0;
        end else begin
            resp_valid <= cmd_valid;
            resp_ack   <= cmd_ok;           // reserved codes answer nack
            resp_data  <= rd_mux;
            atten_ratio_select <=
                config_q[hvr_pkg::CFG_ATTEN_RATIO_SELECT];
            lowv_detect_enable <=
                config_q[hvr_pkg::CFG_LOWV_DETECT_ENABLE];
            atten_diag_current_enable <=
                config_q[hvr_pkg::CFG_ATTEN_DIAG_ENABLE];
            transmitter_enable <= config_q[hvr_pkg::CFG_TX_ENABLE];
            bus_driver_on <= config_q[hvr_pkg::CFG_TX_ENABLE]
                             && !drv_off_q;
            // interrupt stands until a status read lands with no live short
            hv_irq <= irq_d;
        end
    end

    // ****************************************************
    // assertions
    // ****************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_q);

    a_reenable_self_clear: assert property (
        is_wr && cmd_wdata[hvr_pkg::CFG_DRIVER_REENABLE] ##1 !is_wr
        |=> !cfg_q)
        else $error("re-enable bit did not self clear");

    a_shutdown_on_short: assert property (
        short_now && autodis |-> ##2 !bus_driver_on)
        else $error("driver stayed on during short");

    a_autodis_suppressed: assert property (
        short_now && !autodis && !drv_off_q |=> !drv_off_q)
        else $error("driver shut with auto-disable off");

    a_event_sticky: assert property (
        event_q && !is_rsta |=> event_q)
        else $error("short event flag lost without read");

    a_event_read_clear: assert property (
        is_rsta && !short_now |=> !event_q)
        else $error("status read did not clear event");

    a_status_read_data: assert property (
        is_rsta |=> resp_valid && resp_data[7:4] == REVISION_ID
                    && !resp_data[3])
        else $error("status read data wrong");

    a_fixed_read_data: assert property (
        is_rfix |=> resp_ack && resp_data == hvr_pkg::FIXED_PATTERN)
        else $error("fixed pattern read wrong");

    a_config_top_zero: assert property (
        is_wr |=> config_q[7:6] == 2'b00
                  && config_q[1:0] == $past(cmd_wdata[1:0]))
        else $error("config write layout wrong");

    a_lowv_gated: assert property (
        !config_q[hvr_pkg::CFG_LOWV_DETECT_ENABLE] |=> !lowv_q)
        else $error("low-voltage flag set while disabled");

    a_irq_follows_event: assert property (
        short_now |=> hv_irq)
        else $error("interrupt missing after short");
endmodule // hvr_regs

`default_nettype wire

// ==== hvr_regs_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module hvr_regs_test;
    logic        clk = 1'b0, resetn = 1'b0, req = 1'b0;
    logic        dom = 1'b0, ovc = 1'b0, sup = 1'b0;
    logic [7:0]  rcode = 8'h00, rdata = 8'h00, cfg, w, c;
    logic        cv, rv, ack, ars, lde, adc, txe, bdo, irq;
    logic [7:0]  cc, cw, rd;
    logic [31:0] seed = 32'd48;
    int          n_mismatch = 0, checked = 0;
    always #4 clk = ~clk;
    hvr_ctrl_model u_hvr_ctrl_model (.clk(clk), .req(req), .req_code(rcode),
        .req_wdata(rdata), .cmd_valid(cv), .cmd_code(cc), .cmd_wdata(cw));
    hvr_regs u_hvr_regs (.clk(clk), .resetn(resetn), .cmd_valid(cv),
        .cmd_code(cc), .cmd_wdata(cw), .resp_valid(rv), .resp_ack(ack),
        .resp_data(rd), .bus_dominant(dom), .pin_overcurrent(ovc),
        .supply_above_limit(sup), .atten_ratio_select(ars),
        .lowv_detect_enable(lde), .atten_diag_current_enable(adc),
        .transmitter_enable(txe), .bus_driver_on(bdo), .hv_irq(irq));
    // ****
    // helpers
    // ****
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // expected status byte; low flag only counts while detection is on
    function automatic logic [7:0] sta(input logic sc, input logic ev);
        return {hvr_pkg::REVISION_DEFAULT, 1'b0, cfg[4] & sup, sc, ev};
    endfunction
    task automatic summarize();
        if (n_mismatch == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one keyhole command, answer awaited under a bound
    task automatic cmd(input logic [7:0] k, d, input logic ea,
                       input logic [7:0] ed);
        @(posedge clk);
        req <= 1'b1;
        rcode <= k;
        rdata <= d;
        @(posedge clk);
        req <= 1'b0;
        #1;
        for (int i = 0; i < 4 && rv !== 1'b1; i++) begin
            tick(1);
        end
        if (rv !== 1'b1) begin
            n_mismatch++;
            $display("[FAIL] resp_valid exp 1 got %b", rv);
            summarize();
        end else begin
            chk("resp_ack", {7'h00, ea}, {7'h00, ack});
            chk("resp_data", ed, rd);
        end
    endtask
    task automatic short_on(input logic v);
        @(posedge clk);
        dom <= v;
        ovc <= v;
        tick(3);
    endtask
    // ****
    // main sequence
    // ****
    initial begin
        cfg = 8'h00;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        tick(2);
        chk("drv_on", 8'h00, {7'h00, bdo});
        cmd(hvr_pkg::CMD_READ_CONFIG, 8'h00, 1'b1, 8'h00);
        cmd(hvr_pkg::CMD_READ_FIXED, 8'h00, 1'b1, 8'h82);
        cmd(hvr_pkg::CMD_READ_STATUS, 8'h00, 1'b1, sta(1'b0, 1'b0));
        for (int n = 0; n < 16; n++) begin
            seed = xs(seed);
            w = seed[7:0];
            c = seed[15:8];
            // steer clear of the four live codes
            if (c == 8'h00 || c == 8'h02 || c == 8'h05 || c == 8'h08) begin
                c ^= 8'h10;
            end
            @(posedge clk);
            sup <= seed[16];
            cmd(hvr_pkg::CMD_WRITE_CONFIG, w, 1'b1, 8'h00);
            cfg = w & 8'h3b;
            // reserved code after the write must leave config untouched
            cmd(c, ~w, 1'b0, 8'h00);
            chk("ctl", {3'h0, cfg[5:3], cfg[0], cfg[0]},
                {3'h0, ars, lde, adc, txe, bdo});
            cmd(hvr_pkg::CMD_READ_CONFIG, 8'h00, 1'b1, cfg);
            cmd(hvr_pkg::CMD_READ_STATUS, 8'h00, 1'b1, sta(1'b0, 1'b0));
        end
        // mid-run reset: outputs drop at once, config reads zero again
        @(posedge clk);
        resetn <= 1'b0;
        tick(2);
        chk("ctl_rst", 8'h00, {3'h0, ars, lde, adc, txe, bdo});
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        cfg = 8'h00;
        tick(2);
        cmd(hvr_pkg::CMD_READ_CONFIG, 8'h00, 1'b1, 8'h00);
        cmd(hvr_pkg::CMD_READ_STATUS, 8'h00, 1'b1, sta(1'b0, 1'b0));
        // short with auto-disable on: driver drops, re-enable waits
        cmd(hvr_pkg::CMD_WRITE_CONFIG, 8'h01, 1'b1, 8'h00);
        cfg = 8'h01;
        short_on(1'b1);
        chk("drv_irq", 8'h01, {6'h00, bdo, irq});
        cmd(hvr_pkg::CMD_WRITE_CONFIG, 8'h05, 1'b1, 8'h00);
        tick(2);
        chk("drv_on", 8'h00, {7'h00, bdo});
        short_on(1'b0);
        cmd(hvr_pkg::CMD_READ_STATUS, 8'h00, 1'b1, sta(1'b0, 1'b1));
        cmd(hvr_pkg::CMD_READ_STATUS, 8'h00, 1'b1, sta(1'b0, 1'b0));
        tick(1);
        chk("irq", 8'h00, {7'h00, irq});
        cmd(hvr_pkg::CMD_WRITE_CONFIG, 8'h05, 1'b1, 8'h00);
        tick(2);
        chk("drv_on", 8'h01, {7'h00, bdo});
        // auto-disable suppressed: driver stays, interrupt still raised
        cmd(hvr_pkg::CMD_WRITE_CONFIG, 8'h03, 1'b1, 8'h00);
        cfg = 8'h03;
        short_on(1'b1);
        chk("drv_irq", 8'h03, {6'h00, bdo, irq});
        cmd(hvr_pkg::CMD_READ_STATUS, 8'h00, 1'b1, sta(1'b1, 1'b1));
        summarize();
    end
endmodule // hvr_regs_test
`default_nettype wire
